// *** dv/t16_pin_model.sv ***
// model of the external input pins and the timer output pin
`timescale 1ns/100ps

module t16_pin_model (
  input  wire logic clk,
  input  wire logic want_0,
  input  wire logic want_1,
  output logic      timer_input_0,
  output logic      timer_input_1,
  input  wire logic timer_output_pin,
  output int        toggle_count
);
  logic last_out;

  // pins move just after a clock edge, like any outside driver
  always @(posedge clk) begin
    #1;
    timer_input_0 = want_0;
    timer_input_1 = want_1;
  end

  // count timer output toggles seen at the pin
  initial begin
    timer_input_0 = 1'b0;
    timer_input_1 = 1'b0;
    toggle_count = 0;
    last_out = 1'b0;
  end
  always @(posedge clk) begin
    if (timer_output_pin !== last_out) toggle_count++;
    last_out = timer_output_pin;
  end
endmodule : t16_pin_model

// *** dv/t16_tb_top.sv ***
// self-checking testbench of the capture/compare timer core
`timescale 1ns/100ps

module timer16_capture_compare_core_tb_top;
  import t16_pkg::*;
  logic clk = 0, reset_n = 0, tick = 0, sel = 0, wr = 0, seen_b = 0;
  logic es_hi = 0, es_lo = 0, ti0, ti1, want_0 = 0, want_1 = 0;
  logic [2:0] ctl = 3'h0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic rvalid, tout, irq_a, irq_b;
  t16_mode_e mode = T16_MODE_STOP;
  t16_edge_e ti1_es = T16_EDGE_RISE;
  int err_total = 0, cmp_count = 0, cycles = 0, toggles, n, t0;

  t16_core uut (.clk(clk), .reset_n(reset_n), .ce(1'b1),
    .count_tick(tick), .run_mode(mode), .capcmp_control(ctl),
    .edge_select_hi(es_hi), .edge_select_lo(es_lo),
    .ti1_edge_select(ti1_es), .timer_input_0(ti0), .timer_input_1(ti1),
    .cpu_sel(sel), .cpu_wr(wr), .cpu_addr(addr), .cpu_wdata(wdata),
    .cpu_rdata(rdata), .cpu_rvalid(rvalid), .timer_output_pin(tout),
    .match_irq_a(irq_a), .match_irq_b(irq_b));
  t16_pin_model pins (.clk(clk), .want_0(want_0), .want_1(want_1),
    .timer_input_0(ti0), .timer_input_1(ti1), .timer_output_pin(tout),
    .toggle_count(toggles));

  // clock, watchdog and match-b monitor
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (irq_b === 1'b1) seen_b = 1'b1;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end

  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [1:0] a, input logic [15:0] d);
    sel = 1; wr = 1; addr = a; wdata = d;
    step(1);
    sel = 0; wr = 0;
    step(1); // idle cycle so back-to-back calls never re-drive sel at once
  endtask : wr_reg
  task rd_reg(input logic [1:0] a, output logic [15:0] d);
    sel = 1; wr = 0; addr = a;
    step(1);
    sel = 0;
    chk({15'h0, rvalid}, 16'h0001);
    d = rdata;
    step(1); // idle cycle between accesses
  endtask : rd_reg
  // stop, then count exactly k ticks in free-run and hold
  task run_ticks(input int k);
    mode = T16_MODE_STOP; step(2);
    mode = T16_MODE_FREE_A; tick = 1; step(k);
    tick = 0; step(2);
  endtask : run_ticks

  task t_reset;
    ctl = 3'b100;
    rd_reg(2'h2, v); chk(v, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task t_regs;
    wr_reg(2'h0, 16'h5a5a); wr_reg(2'h1, 16'ha5a5);
    rd_reg(2'h0, v); chk(v, 16'h5a5a);
    rd_reg(2'h1, v); chk(v, 16'ha5a5);
    rd_reg(2'h3, v); chk(v, 16'h0000);
    $display("test registers done");
  endtask : t_regs
  task t_count;
    ctl = 3'b100;
    run_ticks(20);
    rd_reg(2'h2, v); chk(v, 16'h0014);
    rd_reg(2'h1, v); chk(v, 16'h0014);
    mode = T16_MODE_STOP; step(2);
    rd_reg(2'h2, v); chk(v, 16'h0000);
    $display("test count done");
  endtask : t_count
  task t_match;
    ctl = 3'h0; wr_reg(2'h0, 16'h0002); wr_reg(2'h1, 16'h0001);
    t0 = toggles; seen_b = 0;
    mode = T16_MODE_MATCH_A; tick = 1;
    for (int k = 0; k < 10 && irq_a !== 1'b1; k++) step(1);
    n = 0;
    do begin step(1); n++; end while (irq_a !== 1'b1 && n < 10);
    chk(16'(n), 16'h0003);
    chk({15'h0, seen_b}, 16'h0001);
    chk({15'h0, (toggles - t0) >= 3}, 16'h0001);
    tick = 0; mode = T16_MODE_STOP; step(2);
    $display("test match done");
  endtask : t_match
  task t_capture;
    run_ticks(7);
    ctl = 3'b001; es_hi = 0; es_lo = 0; wr_reg(2'h0, 16'h0000);
    want_0 = 1; step(8);
    rd_reg(2'h0, v); chk(v, 16'h0007);
    es_hi = 1; es_lo = 1; wr_reg(2'h0, 16'h00aa);
    want_0 = 0; step(8); want_0 = 1; step(8);
    rd_reg(2'h0, v); chk(v, 16'h00aa);
    ctl = 3'b100; es_hi = 0; es_lo = 1; wr_reg(2'h1, 16'h0000);
    want_0 = 0; step(8); want_0 = 1; step(8);
    rd_reg(2'h1, v); chk(v, 16'h0007);
    ctl = 3'b011; wr_reg(2'h0, 16'h0000);
    want_1 = 1; step(8);
    rd_reg(2'h0, v); chk(v, 16'h0007);
    $display("test capture done");
  endtask : t_capture

  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  initial begin
    step(10);
    reset_n = 1;
    step(1);
    t_reset();
    t_regs();
    t_count();
    t_match();
    t_capture();
    complete_run();
  end
endmodule : timer16_capture_compare_core_tb_top

// *** src/t16_consts.svh ***
// constants for the 16-bit capture/compare timer core
`ifndef T16_CONSTS_SVH
`define T16_CONSTS_SVH

// cpu access addresses of the three data registers
`define T16_ADDR_CAPA   2'h0
`define T16_ADDR_CAPB   2'h1
`define T16_ADDR_COUNT  2'h2

// bit positions inside capcmp_control
`define T16_CTL_A_MODE  0
`define T16_CTL_A_TRIG  1
`define T16_CTL_B_MODE  2

// reset and step values
`define T16_COUNT_RST   16'h0000
`define T16_COUNT_STEP  16'h0001
`define T16_RDATA_RST   16'h0000

// pwm duty field: 14 bits taken from capcmp_a_value[15:2]
`define T16_PWM_MSB     13
`define T16_DUTY_LSB    2

`endif

// *** src/t16_core.sv ***
// 16-bit up-counter with two capture/compare registers and timer output
// Summary of operation
// RQ1 - pwm mode drives the output with a 14-bit duty setting
// RQ2 - square wave half period spans one up to 2^16 count edges
// RQ3 - one 16-bit counter, two 16-bit capture/compare registers, one output
// RQ4 - control bit 0 selects capture or compare for register a
// RQ5 - register a in compare mode raises match_irq_a on counter equality
// RQ6 - register a holds interval length and pwm pulse width
// RQ7 - register a captures counter on selected input 0 or 1 edge
// RQ8 - input 0 code 00 captures on rising edge, code 01 on falling
// RQ9 - code 10 forbidden; code 11 makes both edges valid, no capture
// RQ10 - software writes both capture/compare registers as whole 16-bit words
// RQ11 - reset leaves both capture/compare registers undefined
// RQ12 - control bit 2 selects capture or compare for register b
// RQ13 - register b in compare mode raises match_irq_b on equality
// RQ14 - register b captures counter on the valid edge of input 0
// RQ15 - counter counts selected pulses; reset clears it to zero
// RQ16 - software sets register b to capture before reading the counter
// RQ17 - a counter read goes through register b, overwriting its value
// RQ18 - run-mode code 000 stops and clears; other codes count
// RQ19 - running counter steps by one per tick and wraps to zero
`timescale 1ns/100ps
`include "t16_consts.svh"

module t16_core (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  input  wire logic              count_tick,
  input  wire t16_pkg::t16_mode_e run_mode,
  input  wire logic [2:0]        capcmp_control,
  input  wire logic              edge_select_hi,
  input  wire logic              edge_select_lo,
  input  wire t16_pkg::t16_edge_e ti1_edge_select,
  input  wire logic              timer_input_0,
  input  wire logic              timer_input_1,
  input  wire logic              cpu_sel,
  input  wire logic              cpu_wr,
  input  wire logic [1:0]        cpu_addr,
  input  wire logic [15:0]       cpu_wdata,
  output logic      [15:0]       cpu_rdata,
  output logic                   cpu_rvalid,
  output logic                   timer_output_pin,
  output logic                   match_irq_a,
  output logic                   match_irq_b
);
  import t16_pkg::*;

  t16_state_s st_r;
  t16_state_s st_nxt;

  logic      rise0;
  logic      fall0;
  logic      rise1;
  logic      fall1;
  t16_edge_e edge0_code;
  logic      valid0;
  logic      valid1;
  logic      capa_ti0;
  logic      running;
  logic      cap_mode_a;
  logic      cap_mode_b;
  logic      cap_a_ev;
  logic      cap_b_ev;
  logic      cnt_read;
  logic      wr_a;
  logic      wr_b;
  logic      changed;
  logic      match_a;
  logic      match_b;
  logic      clr_match;

  // edge qualifier shared by valid-edge and capture-edge decoding
  function automatic logic edge_hit(input t16_edge_e code,
                                    input logic      r,
                                    input logic      f);
    logic hit;
    hit = 1'b0;
    unique case (code)
      T16_EDGE_FALL: hit = f;
      T16_EDGE_RISE: hit = r;
      T16_EDGE_BOTH: hit = r | f;
      T16_EDGE_BAD:  hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit

  // next-state computation
  always_comb begin
    st_nxt = st_r;
    // pin synchronisers, third stage for edge detection
    st_nxt.ti0_s1 = timer_input_0;
    st_nxt.ti0_s2 = st_r.ti0_s1;
    st_nxt.ti0_d  = st_r.ti0_s2;
    st_nxt.ti1_s1 = timer_input_1;
    st_nxt.ti1_s2 = st_r.ti1_s1;
    st_nxt.ti1_d  = st_r.ti1_s2;
    rise0 = st_r.ti0_s2 & ~st_r.ti0_d;
    fall0 = ~st_r.ti0_s2 & st_r.ti0_d;
    rise1 = st_r.ti1_s2 & ~st_r.ti1_d;
    fall1 = ~st_r.ti1_s2 & st_r.ti1_d;
    edge0_code = t16_edge_e'({edge_select_hi, edge_select_lo});
    valid0 = edge_hit(edge0_code, rise0, fall0);
    valid1 = edge_hit(ti1_edge_select, rise1, fall1);
    // capture edge is the opposite of the pin edge; none for both
    capa_ti0 = (edge0_code != T16_EDGE_BOTH)
             & edge_hit(edge0_code, fall0, rise0);          // [RQ8] [RQ9]

    // mode decoding
    running    = (run_mode != T16_MODE_STOP);               // [RQ18]
    cap_mode_a = capcmp_control[`T16_CTL_A_MODE];           // [RQ4]
    cap_mode_b = capcmp_control[`T16_CTL_B_MODE];           // [RQ12]
    cap_a_ev   = cap_mode_a & (capcmp_control[`T16_CTL_A_TRIG]
                               ? valid1 : capa_ti0);        // [RQ7]
    cap_b_ev   = cap_mode_b & valid0;                       // [RQ14]
    cnt_read   = cpu_sel & ~cpu_wr
               & (cpu_addr == `T16_ADDR_COUNT);             // [RQ16]
    wr_a       = cpu_sel & cpu_wr & (cpu_addr == `T16_ADDR_CAPA);
    wr_b       = cpu_sel & cpu_wr & (cpu_addr == `T16_ADDR_CAPB);
    clr_match  = (run_mode == T16_MODE_MATCH_A)
               | (run_mode == T16_MODE_MATCH_B);

    // counter: stop clears, edge modes restart, match modes reload
    changed = 1'b0;
    if (!running) begin
      st_nxt.count = `T16_COUNT_RST;                        // [RQ18]
    end else if (((run_mode == T16_MODE_EDGE_A)
                  | (run_mode == T16_MODE_EDGE_B)) & valid0) begin
      st_nxt.count = `T16_COUNT_RST;
      changed      = 1'b1;
    end else if (count_tick) begin
      changed = 1'b1;
      if (clr_match & ~cap_mode_a & (st_r.count == st_r.capa)) begin
        st_nxt.count = `T16_COUNT_RST;                      // [RQ6] [RQ2]
      end else begin
        st_nxt.count = st_r.count + `T16_COUNT_STEP;        // [RQ19] [RQ15]
      end
    end

    // match requests on arrival at the compare value
    match_a = running & ~cap_mode_a & changed
            & (st_nxt.count == st_r.capa);                  // [RQ5]
    match_b = running & ~cap_mode_b & changed
            & (st_nxt.count == st_r.capb);                  // [RQ13]
    st_nxt.irq_a = match_a;
    st_nxt.irq_b = match_b;

    // timer output: pwm compare or toggle on match
    if (run_mode == T16_MODE_PWM) begin
      st_nxt.tout = (st_nxt.count[`T16_PWM_MSB:0]
                     < st_r.capa[15:`T16_DUTY_LSB]);        // [RQ1] [RQ6]
    end else if (running & (match_a | match_b)) begin
      st_nxt.tout = ~st_r.tout;                             // [RQ2]
    end

    // register a: capture beats a cpu write in the same cycle
    if (cap_a_ev) begin
      st_nxt.capa = st_r.count;                             // [RQ7]
    end else if (wr_a) begin
      st_nxt.capa = cpu_wdata;
    end
    // register b: counter read and capture load the counter
    if (cnt_read | cap_b_ev) begin
      st_nxt.capb = st_r.count;                             // [RQ17] [RQ14]
    end else if (wr_b) begin
      st_nxt.capb = cpu_wdata;
    end

    // read port
    st_nxt.rvalid = cpu_sel & ~cpu_wr;
    unique case (cpu_addr)
      `T16_ADDR_CAPA:  st_nxt.rdata = st_r.capa;
      `T16_ADDR_CAPB:  st_nxt.rdata = st_r.capb;
      `T16_ADDR_COUNT: st_nxt.rdata = st_r.count;           // [RQ17]
      default:         st_nxt.rdata = `T16_RDATA_RST;
    endcase
    if (!(cpu_sel & ~cpu_wr)) begin
      st_nxt.rdata = st_r.rdata;
    end

    // clock enable low freezes everything except the synchronous reset below
    if (!ce) begin
      st_nxt = st_r;
    end
    // synchronous reset; capture/compare registers keep content
    if (!reset_n) begin
      st_nxt        = '0;
      st_nxt.count  = `T16_COUNT_RST;                       // [RQ15]
      st_nxt.rdata  = `T16_RDATA_RST;
      st_nxt.capa   = st_r.capa;                            // [RQ11]
      st_nxt.capb   = st_r.capb;                            // [RQ11]
    end
  end

  // state register
  always_ff @(posedge clk) begin
    st_r <= st_nxt;                                         // [RQ3]
  end

  // outputs straight from the state register
  assign cpu_rdata        = st_r.rdata;
  assign cpu_rvalid       = st_r.rvalid;
  assign timer_output_pin = st_r.tout;
  assign match_irq_a      = st_r.irq_a;
  assign match_irq_b      = st_r.irq_b;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_STOP_CLEARS: assert property ( // [RQ18]
    ce && run_mode == T16_MODE_STOP |=> st_r.count == `T16_COUNT_RST)
    else $error("counter not cleared in stop mode");

  AST_COUNT_STEP: assert property ( // [RQ19]
    ce && count_tick && (run_mode == T16_MODE_PWM
      || run_mode == T16_MODE_FREE_A || run_mode == T16_MODE_FREE_B)
    |=> st_r.count == 16'($past(st_r.count) + `T16_COUNT_STEP))
    else $error("counter did not step by one");

  AST_IRQ_A: assert property ( // [RQ5]
    match_irq_a |-> $past(running) && !$past(cap_mode_a)
      && st_r.count == $past(st_r.capa))
    else $error("match a raised without equality");

  AST_IRQ_B: assert property ( // [RQ13]
    match_irq_b |-> $past(running) && !$past(cap_mode_b)
      && st_r.count == $past(st_r.capb))
    else $error("match b raised without equality");

  AST_CAPTURE_A: assert property ( // [RQ7]
    ce && cap_a_ev |=> st_r.capa == $past(st_r.count))
    else $error("register a missed a capture");

  AST_CAPTURE_POL: assert property ( // [RQ8]
    ce && cap_mode_a && !capcmp_control[`T16_CTL_A_TRIG]
      && edge0_code == T16_EDGE_FALL && rise0
    |=> st_r.capa == $past(st_r.count))
    else $error("rising capture edge ignored for code 00");

  AST_BOTH_NO_CAP: assert property ( // [RQ9]
    ce && cap_mode_a && !capcmp_control[`T16_CTL_A_TRIG]
      && edge0_code == T16_EDGE_BOTH && !wr_a
    |=> $stable(st_r.capa))
    else $error("capture with both-edge code");

  AST_CAPTURE_B: assert property ( // [RQ14]
    ce && cap_mode_b && valid0 |=> st_r.capb == $past(st_r.count))
    else $error("register b missed a capture");

  AST_READ_VIA_B: assert property ( // [RQ17]
    ce && cnt_read |=> cpu_rvalid && cpu_rdata == $past(st_r.count)
      && st_r.capb == $past(st_r.count))
    else $error("counter read did not pass through register b");

  AST_PWM_DUTY: assert property ( // [RQ1]
    ce && run_mode == T16_MODE_PWM
    |=> timer_output_pin == (st_r.count[`T16_PWM_MSB:0]
                             < $past(st_r.capa[15:`T16_DUTY_LSB])))
    else $error("pwm output does not follow duty");

  AST_INTERVAL: assert property ( // [RQ6]
    ce && run_mode == T16_MODE_MATCH_A && count_tick && !cap_mode_a
      && st_r.count == st_r.capa |=> st_r.count == `T16_COUNT_RST)
    else $error("interval counter not reloaded on match");

  AST_TOGGLE: assert property ( // [RQ2]
    ce && running && run_mode != T16_MODE_PWM && (match_a || match_b)
    |=> timer_output_pin != $past(timer_output_pin))
    else $error("square wave did not toggle");

  COV_PWM_RUN:  cover property (ce && run_mode == T16_MODE_PWM ##1
                                timer_output_pin ##1 !timer_output_pin);
  COV_CAP_A:    cover property (ce && cap_a_ev);
  COV_INTERVAL: cover property (match_irq_a ##[1:20] match_irq_a);
  COV_READ:     cover property (ce && cnt_read ##1 cpu_rvalid);

endmodule : t16_core

// *** src/t16_pkg.sv ***
// types for the 16-bit capture/compare timer core
package t16_pkg;

  // run-mode codes from the three run-mode bits
  typedef enum logic [2:0] {
    T16_MODE_STOP    = 3'b000,
    T16_MODE_PWM     = 3'b001,
    T16_MODE_FREE_A  = 3'b010,
    T16_MODE_FREE_B  = 3'b011,
    T16_MODE_EDGE_A  = 3'b100,
    T16_MODE_EDGE_B  = 3'b101,
    T16_MODE_MATCH_A = 3'b110,
    T16_MODE_MATCH_B = 3'b111
  } t16_mode_e;

  // pin valid-edge codes
  typedef enum logic [1:0] {
    T16_EDGE_FALL = 2'b00,
    T16_EDGE_RISE = 2'b01,
    T16_EDGE_BAD  = 2'b10,
    T16_EDGE_BOTH = 2'b11
  } t16_edge_e;

  // complete state of the core
  typedef struct packed {
    logic        ti0_s1;
    logic        ti0_s2;
    logic        ti0_d;
    logic        ti1_s1;
    logic        ti1_s2;
    logic        ti1_d;
    logic [15:0] count;
    logic [15:0] capa;
    logic [15:0] capb;
    logic        tout;
    logic        irq_a;
    logic        irq_b;
    logic [15:0] rdata;
    logic        rvalid;
  } t16_state_s;

endpackage : t16_pkg
